/* File: include/acptc_pkg.sv */
package acptc_pkg;
    // Clock rate and timing figures.
    localparam int unsigned CLK_KHZ        = 25000;
    localparam int unsigned SINK_WAIT_MS   = 500;
    localparam int unsigned TEMP_UPD_MS    = 500;
    localparam int unsigned TEMP_UPD_CYC   = TEMP_UPD_MS * CLK_KHZ;
    localparam int unsigned SINK_WAIT_CYC  = SINK_WAIT_MS * CLK_KHZ;

    // Register byte offsets.
    localparam logic [7:0] OFS_CTRL       = 8'h00;
    localparam logic [7:0] OFS_SINK_CUR   = 8'h04;
    localparam logic [7:0] OFS_REQ_CFG    = 8'h08;
    localparam logic [7:0] OFS_REMOTE     = 8'h0c;
    localparam logic [7:0] OFS_SINK_PDO   = 8'h10;
    localparam logic [7:0] OFS_REQ_OBJ    = 8'h14;
    localparam logic [7:0] OFS_TEMP_CFG   = 8'h18;
    localparam logic [7:0] OFS_TEMP_STAT  = 8'h1c;
    localparam logic [7:0] OFS_IRQ_STAT   = 8'h20;
    localparam logic [7:0] OFS_IRQ_MASK   = 8'h24;
    localparam logic [7:0] OFS_EXTRA_PDO  = 8'h28;

    // Control and remote register fields.
    localparam int CTRL_ACTIVE  = 0;
    localparam int CTRL_EXTRA   = 1;
    localparam int REM_DRD      = 0;
    localparam int REM_UNCHUNK  = 1;

    // Interrupt status bits.
    localparam int IRQ_SHUTDOWN = 0;
    localparam int IRQ_HRESET   = 1;
    localparam int IRQ_TEMP     = 2;
    localparam int IRQ_W        = 3;

    // Reset values.
    localparam logic [9:0]  SINK_CUR_RST  = 10'h00a;
    localparam logic [31:0] REQ_CFG_RST   = 32'h1000_280a;
    localparam logic [15:0] TEMP_CFG_RST  = 16'h5550;

    // Fixed sink capability and request fields.
    localparam logic [1:0] PDO_FIXED     = 2'h0;
    localparam logic [9:0] PDO_5V_50MV   = 10'h064;
    localparam int PDO_COMM_BIT          = 26;
    localparam int PDO_DRD_BIT           = 25;
    localparam int REQ_COMM_BIT          = 25;
    localparam int REQ_SUSP_BIT          = 24;
    localparam int REQ_UNCHUNK_BIT       = 23;

    typedef enum logic [1:0] {
        ACPTC_NO_VBUS,
        ACPTC_WAIT_CAPS,
        ACPTC_HAVE_CAPS
    } acptc_wait_t;
endpackage : acptc_pkg

/* File: src/acptc_top.sv */
// Added by the designer: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
// Functional notes
// - Restricted message set until Active; then negotiate.
// - Wait sink capability timer before Hard Reset.
// - Sink capability advertises fixed 5 V, 50 mV units.
// - Fixed, flag and reserved sink capability bits.
// - Dual-role data bit mirrors far end.
// - Sink operational current programmable, 10 mA.
// - Optional extra capability; minimum offer still works.
// - Request reserved zero, comm and suspend set.
// - Request unchunked bit copied from far end.
// - Request currents programmable, 10 mA units.
// - Over temperature forces eSS.Disabled.
// - Get_Status reports thermal shutdown.
// - Billboard shown while in shutdown.
// - Shutdown cleared only by disconnect, Hard Reset.
// - Discover_ID carries maximum internal temperature.
// - Get_Status carries present internal temperature.
// - Temperature report refreshed within 500 ms.
// - Temperature in Celsius, threshold sets shutdown.
module acptc_top #(
    parameter int unsigned SINK_WAIT_CYC = acptc_pkg::SINK_WAIT_CYC,
    parameter int unsigned TEMP_UPD_CYC  = acptc_pkg::TEMP_UPD_CYC
) (
    input  wire logic        clk_in,
    input  wire logic        srst_in,
    input  wire logic        ce_in,
    input  wire logic [7:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    input  wire logic [3:0]  avs_byteenable_in,
    output logic      [31:0] avs_readdata_out,
    output logic             avs_waitrequest_out,
    input  wire logic        vbus_in,
    input  wire logic        src_caps_in,
    input  wire logic        hard_reset_in,
    input  wire logic        disconnect_in,
    input  wire logic [7:0]  temp_in,
    output logic             restricted_msgs_out,
    output logic             hard_reset_req_out,
    output logic      [31:0] sink_pdo_out,
    output logic      [31:0] extra_pdo_out,
    output logic             extra_pdo_en_out,
    output logic      [31:0] req_obj_out,
    output logic             ess_disable_out,
    output logic             billboard_out,
    output logic             status_shutdown_out,
    output logic      [7:0]  status_temp_out,
    output logic      [7:0]  discover_max_temp_out,
    output logic             irq_out
);

    logic [1:0]  ctrl_r;
    logic [9:0]  sink_cur_r;
    logic [31:0] req_cfg_r;
    logic [1:0]  remote_r;
    logic [15:0] temp_cfg_r;
    logic [31:0] extra_pdo_r;
    logic [acptc_pkg::IRQ_W-1:0] irq_stat_r;
    logic [acptc_pkg::IRQ_W-1:0] irq_mask_r;
    logic [31:0] rdata_nxt;
    logic        wait_r;
    logic        acc_done;
    logic        wr_acc;
    logic [31:0] pdo_nxt;
    logic [31:0] req_nxt;
    logic        shut_r;
    logic        shut_set;
    logic        shut_clr;
    logic [7:0]  temp_rep_r;
    logic [31:0] upd_cnt_r;
    logic        upd_tick;
    logic [31:0] wait_cnt_r;
    acptc_pkg::acptc_wait_t wait_st_r;
    logic        hr_fire;
    logic [acptc_pkg::IRQ_W-1:0] ev;

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  be);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge

    // One wait state per access; the access completes while waitrequest
    // is low, so writes land on that same edge.
    assign acc_done = (avs_read_in || avs_write_in) && !wait_r;
    assign wr_acc   = avs_write_in && acc_done;

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            wait_r <= 1'b1;
        end else if (ce_in) begin
            wait_r <= !((avs_read_in || avs_write_in) && wait_r);
        end
    end

    always_comb begin
        rdata_nxt = 32'h0000_0000;
        unique case (avs_address_in)
            acptc_pkg::OFS_CTRL:      rdata_nxt = {30'h0, ctrl_r};
            acptc_pkg::OFS_SINK_CUR:  rdata_nxt = {22'h0, sink_cur_r};
            acptc_pkg::OFS_REQ_CFG:   rdata_nxt = req_cfg_r;
            acptc_pkg::OFS_REMOTE:    rdata_nxt = {30'h0, remote_r};
            acptc_pkg::OFS_SINK_PDO:  rdata_nxt = pdo_nxt;
            acptc_pkg::OFS_REQ_OBJ:   rdata_nxt = req_nxt;
            acptc_pkg::OFS_TEMP_CFG:  rdata_nxt = {16'h0, temp_cfg_r};
            acptc_pkg::OFS_TEMP_STAT: rdata_nxt = {23'h0, shut_r, temp_rep_r};
            acptc_pkg::OFS_IRQ_STAT:  rdata_nxt = {29'h0, irq_stat_r};
            acptc_pkg::OFS_IRQ_MASK:  rdata_nxt = {29'h0, irq_mask_r};
            acptc_pkg::OFS_EXTRA_PDO: rdata_nxt = extra_pdo_r;
            default:                  rdata_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            avs_readdata_out <= 32'h0000_0000;
        end else if (ce_in && avs_read_in && wait_r) begin
            avs_readdata_out <= rdata_nxt;
        end
    end

    assign avs_waitrequest_out = wait_r;

    // Software-owned configuration registers.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            ctrl_r      <= 2'h0;
            sink_cur_r  <= acptc_pkg::SINK_CUR_RST;
            req_cfg_r   <= acptc_pkg::REQ_CFG_RST;
            remote_r    <= 2'h0;
            temp_cfg_r  <= acptc_pkg::TEMP_CFG_RST;
            extra_pdo_r <= 32'h0000_0000;
            irq_mask_r  <= '0;
        end else if (ce_in && wr_acc) begin
            unique case (avs_address_in)
                acptc_pkg::OFS_CTRL: begin
                    ctrl_r <= 2'(merge({30'h0, ctrl_r},
                        avs_writedata_in, avs_byteenable_in));
                end
                acptc_pkg::OFS_SINK_CUR: begin
                    sink_cur_r <= 10'(merge({22'h0, sink_cur_r},
                        avs_writedata_in, avs_byteenable_in));
                end
                acptc_pkg::OFS_REQ_CFG: begin
                    req_cfg_r <= merge(req_cfg_r, avs_writedata_in,
                                       avs_byteenable_in);
                end
                acptc_pkg::OFS_REMOTE: begin
                    remote_r <= 2'(merge({30'h0, remote_r},
                        avs_writedata_in, avs_byteenable_in));
                end
                acptc_pkg::OFS_TEMP_CFG: begin
                    temp_cfg_r <= 16'(merge({16'h0, temp_cfg_r},
                        avs_writedata_in, avs_byteenable_in));
                end
                acptc_pkg::OFS_IRQ_MASK: begin
                    irq_mask_r <= avs_byteenable_in[0] ?
                                  avs_writedata_in[acptc_pkg::IRQ_W-1:0] :
                                  irq_mask_r;
                end
                acptc_pkg::OFS_EXTRA_PDO: begin
                    extra_pdo_r <= merge(extra_pdo_r, avs_writedata_in,
                                         avs_byteenable_in);
                end
                default: begin
                end
            endcase
        end
    end

    // Sink capability object for the Active contract.
    always_comb begin
        pdo_nxt = 32'h0000_0000;
        pdo_nxt[31:30] = acptc_pkg::PDO_FIXED;
        pdo_nxt[acptc_pkg::PDO_COMM_BIT] = 1'b1;
        pdo_nxt[acptc_pkg::PDO_DRD_BIT] =
            remote_r[acptc_pkg::REM_DRD];
        pdo_nxt[19:10] = acptc_pkg::PDO_5V_50MV;
        pdo_nxt[9:0]   = sink_cur_r;
    end

    // Request object; reserved, giveback and mismatch stay zero.
    always_comb begin
        req_nxt = 32'h0000_0000;
        req_nxt[30:28] = req_cfg_r[30:28];
        req_nxt[acptc_pkg::REQ_COMM_BIT] = 1'b1;
        req_nxt[acptc_pkg::REQ_SUSP_BIT] = 1'b1;
        req_nxt[acptc_pkg::REQ_UNCHUNK_BIT] =
            remote_r[acptc_pkg::REM_UNCHUNK];
        req_nxt[19:0] = req_cfg_r[19:0];
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            restricted_msgs_out <= 1'b1;
            sink_pdo_out        <= 32'h0000_0000;
            req_obj_out         <= 32'h0000_0000;
            extra_pdo_out       <= 32'h0000_0000;
            extra_pdo_en_out    <= 1'b0;
        end else if (ce_in) begin
            restricted_msgs_out <= !ctrl_r[acptc_pkg::CTRL_ACTIVE];
            sink_pdo_out        <= pdo_nxt;
            req_obj_out         <= req_nxt;
            // The extra offer is only an addition; the minimum stays first.
            extra_pdo_out       <= extra_pdo_r;
            extra_pdo_en_out    <= ctrl_r[acptc_pkg::CTRL_EXTRA] &&
                                   ctrl_r[acptc_pkg::CTRL_ACTIVE];
        end
    end

    // Wait for Source_Capabilities after VBUS; a Hard Reset on timeout.
    assign hr_fire = (wait_st_r == acptc_pkg::ACPTC_WAIT_CAPS) &&
                     (wait_cnt_r >= SINK_WAIT_CYC - 1) && !src_caps_in;

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            wait_st_r          <= acptc_pkg::ACPTC_NO_VBUS;
            wait_cnt_r         <= 32'h0000_0000;
            hard_reset_req_out <= 1'b0;
        end else if (ce_in) begin
            hard_reset_req_out <= 1'b0;
            if (!vbus_in || disconnect_in) begin
                wait_st_r  <= acptc_pkg::ACPTC_NO_VBUS;
                wait_cnt_r <= 32'h0000_0000;
            end else begin
                unique case (wait_st_r)
                    acptc_pkg::ACPTC_NO_VBUS: begin
                        wait_st_r  <= acptc_pkg::ACPTC_WAIT_CAPS;
                        wait_cnt_r <= 32'h0000_0000;
                    end
                    acptc_pkg::ACPTC_WAIT_CAPS: begin
                        if (src_caps_in) begin
                            wait_st_r <= acptc_pkg::ACPTC_HAVE_CAPS;
                        end else if (hr_fire) begin
                            hard_reset_req_out <= 1'b1;
                            wait_cnt_r         <= 32'h0000_0000;
                        end else begin
                            wait_cnt_r <= wait_cnt_r + 32'd1;
                        end
                    end
                    acptc_pkg::ACPTC_HAVE_CAPS: begin
                        if (hard_reset_in) begin
                            wait_st_r  <= acptc_pkg::ACPTC_WAIT_CAPS;
                            wait_cnt_r <= 32'h0000_0000;
                        end
                    end
                    default: begin
                        wait_st_r <= acptc_pkg::ACPTC_NO_VBUS;
                    end
                endcase
            end
        end
    end

    // Thermal shutdown latch; a new over-temperature beats a clear.
    assign shut_set = (temp_in >= temp_cfg_r[7:0]);
    assign shut_clr = disconnect_in || hard_reset_in;

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            shut_r <= 1'b0;
        end else if (ce_in) begin
            if (shut_set) begin
                shut_r <= 1'b1;
            end else if (shut_clr) begin
                shut_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            ess_disable_out       <= 1'b0;
            billboard_out         <= 1'b0;
            status_shutdown_out   <= 1'b0;
            discover_max_temp_out <= 8'h00;
        end else if (ce_in) begin
            ess_disable_out       <= shut_r;
            billboard_out         <= shut_r;
            status_shutdown_out   <= shut_r;
            discover_max_temp_out <= temp_cfg_r[15:8];
        end
    end

    // Periodic refresh of the reported internal temperature.
    assign upd_tick = (upd_cnt_r >= TEMP_UPD_CYC - 1);

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            upd_cnt_r  <= 32'h0000_0000;
            temp_rep_r <= 8'h00;
        end else if (ce_in) begin
            if (upd_tick) begin
                upd_cnt_r  <= 32'h0000_0000;
                temp_rep_r <= temp_in;
            end else begin
                upd_cnt_r <= upd_cnt_r + 32'h0000_0001;
            end
        end
    end

    assign status_temp_out = temp_rep_r;

    // Sticky events, write one to clear; a new event wins over the clear.
    assign ev = {upd_tick, hr_fire, shut_set && !shut_r};

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            irq_stat_r <= '0;
        end else if (ce_in) begin
            if (wr_acc && avs_address_in == acptc_pkg::OFS_IRQ_STAT &&
                avs_byteenable_in[0]) begin
                irq_stat_r <= (irq_stat_r &
                              ~avs_writedata_in[acptc_pkg::IRQ_W-1:0]) | ev;
            end else begin
                irq_stat_r <= irq_stat_r | ev;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            irq_out <= 1'b0;
        end else if (ce_in) begin
            irq_out <= |(irq_stat_r & irq_mask_r);
        end
    end

    a_restrict_follows: assert property (@(posedge clk_in)
        disable iff (srst_in || !ce_in)
        ##1 ($past(ce_in) && !$past(srst_in)) |->
        restricted_msgs_out == !$past(ctrl_r[acptc_pkg::CTRL_ACTIVE]))
        else $error("restricted flag does not track Active");
    a_hr_after_wait: assert property (@(posedge clk_in)
        disable iff (srst_in || !ce_in)
        $rose(hard_reset_req_out) |->
        $past(wait_cnt_r) == SINK_WAIT_CYC - 1)
        else $error("hard reset issued before wait expired");
    a_pdo_fields: assert property (@(posedge clk_in)
        disable iff (srst_in)
        ##1 !$past(srst_in) |->
        sink_pdo_out[19:10] == acptc_pkg::PDO_5V_50MV &&
        sink_pdo_out[31:26] == 6'h01 && sink_pdo_out[24:20] == 5'h00)
        else $error("sink capability fixed fields wrong");
    a_pdo_mirror: assert property (@(posedge clk_in)
        disable iff (srst_in || !ce_in)
        ##1 ($past(ce_in) && !$past(srst_in)) |->
        sink_pdo_out[acptc_pkg::PDO_DRD_BIT] ==
        $past(remote_r[acptc_pkg::REM_DRD]) &&
        sink_pdo_out[9:0] == $past(sink_cur_r))
        else $error("sink capability variable fields wrong");
    a_req_fields: assert property (@(posedge clk_in)
        disable iff (srst_in)
        ##1 (req_obj_out[31] == 1'b0 && req_obj_out[27:26] == 2'h0 &&
             req_obj_out[22:20] == 3'h0))
        else $error("request object reserved fields wrong");
    a_shut_outputs: assert property (@(posedge clk_in)
        disable iff (srst_in || !ce_in)
        shut_set ##1 ce_in |=> ess_disable_out && billboard_out &&
        status_shutdown_out)
        else $error("shutdown not reflected on outputs");
    a_shut_sticky: assert property (@(posedge clk_in)
        disable iff (srst_in || !ce_in)
        shut_r && !shut_clr |=> shut_r)
        else $error("shutdown cleared without disconnect or hard reset");
    a_temp_refresh: assert property (@(posedge clk_in)
        disable iff (srst_in)
        upd_cnt_r < TEMP_UPD_CYC)
        else $error("temperature refresh period exceeded");
    a_temp_sample: assert property (@(posedge clk_in)
        disable iff (srst_in || !ce_in)
        upd_tick |=> status_temp_out == $past(temp_in))
        else $error("reported temperature not refreshed");
    a_irq_level: assert property (@(posedge clk_in)
        disable iff (srst_in || !ce_in)
        ##1 $past(ce_in) |->
        irq_out == |($past(irq_stat_r) & $past(irq_mask_r)))
        else $error("interrupt output does not follow status");

    c_hard_reset: cover property (@(posedge clk_in)
        disable iff (srst_in) $rose(hard_reset_req_out));
    c_shutdown: cover property (@(posedge clk_in)
        disable iff (srst_in) $rose(billboard_out));
    c_shut_clear: cover property (@(posedge clk_in)
        disable iff (srst_in) $fell(ess_disable_out));
    c_temp_tick: cover property (@(posedge clk_in)
        disable iff (srst_in) upd_tick);

endmodule : acptc_top

/* File: sim/acptc_pd_partner.sv */
`timescale 1ns/10ps
// Behavioural port partner: reports link events one cycle after they are driven.
module acptc_pd_partner #(
    parameter int POLL_CYC = 8
) (
    input  wire logic       clk_in,
    input  wire logic       srst_in,
    input  wire logic       vbus_on_in,
    input  wire logic       caps_in,
    input  wire logic       hr_in,
    input  wire logic       unplug_in,
    input  wire logic [7:0] temp_rpt_in,
    output logic            vbus_out,
    output logic            src_caps_out,
    output logic            hard_reset_out,
    output logic            disconnect_out,
    output logic      [7:0] polled_temp_out
);
    int poll_cnt_r;

    always_ff @(posedge clk_in) begin
        vbus_out       <= vbus_on_in & ~unplug_in;
        src_caps_out   <= caps_in;
        hard_reset_out <= hr_in;
        disconnect_out <= unplug_in;
    end

    // Reads the reported temperature on a fixed polling period.
    always_ff @(posedge clk_in) begin
        if (srst_in || poll_cnt_r == POLL_CYC - 1) begin
            poll_cnt_r <= 0;
        end else begin
            poll_cnt_r <= poll_cnt_r + 1;
        end
        if (poll_cnt_r == POLL_CYC - 1) begin
            polled_temp_out <= temp_rpt_in;
        end
    end
endmodule : acptc_pd_partner

/* File: sim/tb.sv */
`timescale 1ns/10ps
module tb;
    logic        clk_in = 1'b0;
    logic        srst_in = 1'b1;
    logic [7:0]  avs_address_in = 8'h00;
    logic        avs_read_in = 1'b0;
    logic        avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h0;
    logic [31:0] avs_readdata_out, sink_pdo_out, extra_pdo_out, req_obj_out;
    logic        avs_waitrequest_out, restricted_msgs_out, hard_reset_req_out;
    logic        extra_pdo_en_out, ess_disable_out, billboard_out, irq_out;
    logic        status_shutdown_out, vbus_in, src_caps_in, hard_reset_in;
    logic        disconnect_in;
    logic        vbus_on = 1'b0, caps = 1'b0, hr = 1'b0, unplug = 1'b0;
    logic [7:0]  temp_in = 8'h19;
    logic [7:0]  status_temp_out, discover_max_temp_out, polled;
    logic [31:0] q, cfg;
    logic [9:0]  cur;
    logic [1:0]  rem;
    int          fails = 0;
    int          num_checks = 0;
    int          n;

    always #20 clk_in = ~clk_in;

    acptc_top #(.SINK_WAIT_CYC(20), .TEMP_UPD_CYC(16)) dut_u (
        .clk_in, .srst_in, .ce_in(1'b1), .avs_address_in, .avs_read_in,
        .avs_write_in, .avs_writedata_in, .avs_byteenable_in(4'hf),
        .avs_readdata_out, .avs_waitrequest_out, .vbus_in, .src_caps_in,
        .hard_reset_in, .disconnect_in, .temp_in, .restricted_msgs_out,
        .hard_reset_req_out, .sink_pdo_out, .extra_pdo_out,
        .extra_pdo_en_out, .req_obj_out, .ess_disable_out, .billboard_out,
        .status_shutdown_out, .status_temp_out, .discover_max_temp_out,
        .irq_out);

    acptc_pd_partner #(.POLL_CYC(8)) partner_u (
        .clk_in, .srst_in, .vbus_on_in(vbus_on), .caps_in(caps),
        .hr_in(hr), .unplug_in(unplug), .temp_rpt_in(status_temp_out),
        .vbus_out(vbus_in), .src_caps_out(src_caps_in),
        .hard_reset_out(hard_reset_in), .disconnect_out(disconnect_in),
        .polled_temp_out(polled));

    function automatic logic [31:0] exp_pdo(input logic [9:0] c,
                                            input logic d);
        return {2'h0, 3'h0, 1'b1, d, 2'h0, 3'h0, 10'h064, c};
    endfunction : exp_pdo

    function automatic logic [31:0] exp_req(input logic [31:0] c,
                                            input logic u);
        return {1'b0, c[30:28], 2'h0, 2'h3, u, 3'h0, c[19:10], c[9:0]};
    endfunction : exp_req

    task automatic give_verdict;
        $display("checks=%0d fails=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Holds the request until waitrequest is sampled low; one idle edge
    // follows, so that a next call never drives a strobe twice at once.
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        avs_address_in   <= a;
        avs_writedata_in <= d;
        avs_write_in     <= w;
        avs_read_in      <= ~w;
        @(posedge clk_in);
        while (avs_waitrequest_out !== 1'b0) begin
            @(posedge clk_in);
        end
        q = avs_readdata_out;
        avs_write_in <= 1'b0;
        avs_read_in  <= 1'b0;
        @(posedge clk_in);
    endtask : bus

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(q, e);
    endtask : rdc

    task automatic wait_hr(output int m);
        m = 0;
        while (hard_reset_req_out !== 1'b1 && m < 100) begin
            @(posedge clk_in);
            m++;
        end
    endtask : wait_hr

    task automatic shut_bits(input logic [2:0] e);
        chk({29'h0, ess_disable_out, billboard_out, status_shutdown_out},
            {29'h0, e});
    endtask : shut_bits

    initial begin
        #(40 * 6000);
        fails++;
        give_verdict();
    end

    initial begin
        q = $urandom(32'h0671f6bc);
        repeat (6) @(posedge clk_in);
        srst_in <= 1'b0;
        @(posedge clk_in);
        chk({31'h0, restricted_msgs_out}, 32'h1);
        chk({31'h0, avs_waitrequest_out}, 32'h1);
        rdc(acptc_pkg::OFS_SINK_CUR, 32'h0000_000a);
        rdc(acptc_pkg::OFS_REQ_CFG, 32'h1000_280a);
        rdc(acptc_pkg::OFS_TEMP_CFG, 32'h0000_5550);
        bus(1'b1, 8'h2c, 32'hffff_ffff);
        rdc(8'h2c, 32'h0);
        bus(1'b1, acptc_pkg::OFS_CTRL, 32'h1);
        repeat (2) @(posedge clk_in);
        chk({31'h0, restricted_msgs_out}, 32'h0);
        for (int i = 0; i < 5; i++) begin
            cur = (i == 0) ? 10'h3ff : 10'($urandom);
            rem = 2'($urandom);
            cfg = (i == 0) ? 32'hffff_ffff : $urandom;
            bus(1'b1, acptc_pkg::OFS_SINK_CUR, {22'h0, cur});
            bus(1'b1, acptc_pkg::OFS_REMOTE, {30'h0, rem});
            bus(1'b1, acptc_pkg::OFS_REQ_CFG, cfg);
            bus(1'b1, acptc_pkg::OFS_SINK_PDO, 32'hffff_ffff);
            repeat (2) @(posedge clk_in);
            chk(sink_pdo_out, exp_pdo(cur, rem[0]));
            chk(req_obj_out, exp_req(cfg, rem[1]));
            rdc(acptc_pkg::OFS_SINK_PDO, exp_pdo(cur, rem[0]));
        end
        cfg = $urandom;
        bus(1'b1, acptc_pkg::OFS_EXTRA_PDO, cfg);
        bus(1'b1, acptc_pkg::OFS_CTRL, 32'h3);
        repeat (2) @(posedge clk_in);
        chk(extra_pdo_out, cfg);
        chk({31'h0, extra_pdo_en_out}, 32'h1);
        bus(1'b1, acptc_pkg::OFS_CTRL, 32'h1);
        repeat (2) @(posedge clk_in);
        chk({31'h0, extra_pdo_en_out}, 32'h0);
        vbus_on <= 1'b1;
        wait_hr(n);
        chk({31'h0, n >= 20 && n <= 24}, 32'h1);
        @(posedge clk_in);
        wait_hr(n);
        chk({31'h0, n >= 19 && n <= 22}, 32'h1);
        // Hard reset issued, plus the periodic temperature refresh event.
        rdc(acptc_pkg::OFS_IRQ_STAT, 32'h6);
        caps <= 1'b1;
        @(posedge clk_in);
        caps <= 1'b0;
        n = 0;
        repeat (40) begin
            @(posedge clk_in);
            n += int'(hard_reset_req_out === 1'b1);
        end
        chk(n, 0);
        bus(1'b1, acptc_pkg::OFS_IRQ_MASK, 32'h1);
        for (int e = 0; e < 2; e++) begin
            bus(1'b1, acptc_pkg::OFS_IRQ_STAT, 32'h7);
            temp_in <= 8'h50;
            repeat (4) @(posedge clk_in);
            shut_bits(3'h7);
            chk({31'h0, irq_out}, 32'h1);
            bus(1'b0, acptc_pkg::OFS_TEMP_STAT, 32'h0);
            chk({31'h0, q[8]}, 32'h1);
            temp_in <= 8'h20;
            repeat (6) @(posedge clk_in);
            shut_bits(3'h7);
            bus(1'b1, acptc_pkg::OFS_IRQ_STAT, 32'h1);
            repeat (2) @(posedge clk_in);
            chk({31'h0, irq_out}, 32'h0);
            if (e == 0) hr <= 1'b1;
            else unplug <= 1'b1;
            @(posedge clk_in);
            hr     <= 1'b0;
            unplug <= 1'b0;
            repeat (3) @(posedge clk_in);
            shut_bits(3'h0);
        end
        cur = 10'($urandom);
        bus(1'b1, acptc_pkg::OFS_TEMP_CFG, {16'h0, cur[7:0], 8'h50});
        repeat (2) @(posedge clk_in);
        chk({24'h0, discover_max_temp_out}, {24'h0, cur[7:0]});
        for (int i = 0; i < 4; i++) begin
            temp_in <= (i == 0) ? 8'h4f : 8'($urandom_range(79, 0));
            repeat (20) @(posedge clk_in);
            chk({24'h0, status_temp_out}, {24'h0, temp_in});
            chk({31'h0, status_shutdown_out}, 32'h0);
        end
        repeat (10) @(posedge clk_in);
        chk({24'h0, polled}, {24'h0, temp_in});
        give_verdict();
    end
endmodule : tb
